// ===== rtl/fss_status_setup.sv
// status, error and setup registers of the flash sequencer
// assumes engine events and window values arrive on mclk, as pulses
// and levels from the sequencer engines; software uses APB
`timescale 1ns/10ps
`include "fss_defines.svh"

module fss_status_setup #(
  parameter int SHIELD_W = 10
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire fss_pkg::fss_apb_req_t apbReq,
  output      fss_pkg::fss_apb_rsp_t apbRsp,
  input  wire fss_pkg::fss_evt_t     engEvt,
  input  wire logic [SHIELD_W-1:0]   shieldFirst,
  input  wire logic [SHIELD_W-1:0]   shieldLast,
  input  wire logic                  shieldUpdate,
  input  wire logic                  extraAreaCluster1,
  output      logic                  mainEngineStart,
  output      logic                  extraEngineStart,
  output      logic                  seqRegInit,
  output      logic                  bootCluster1,
  output      logic [4:0]            cpuFrequencyCode
);
  import fss_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  // window numbers and their plus-one must fit a 16-bit monitor
  if (SHIELD_W < 1 || SHIELD_W > 15) begin : g_bad_width
    $error("SHIELD_W must lie in 1..15");
  end

  // the decode compares whole bytes, so every offset must be word aligned
  localparam logic [7:0] OFF_OR = `FSS_OFF_STATUS_HIGH | `FSS_OFF_ERROR_LOW
                                | `FSS_OFF_INIT_SETTING | `FSS_OFF_REG_INIT
                                | `FSS_OFF_SHIELD_START | `FSS_OFF_SHIELD_END
                                | `FSS_OFF_ENGINE_CTRL;
  if (OFF_OR[1:0] != 2'b00) begin : g_bad_offset
    $error("register offsets must be word aligned");
  end

  // the frequency field must stay below the reserved bit 5
  if (`FSS_FREQ_MSB != 4) begin : g_bad_freq
    $error("frequency field must end at bit 4");
  end

  // ****************************************
  // helpers
  // ****************************************
  // address match against one register offset
  function automatic logic hitReg(input logic [7:0] addr,
                                  input logic [7:0] off);
    hitReg = (addr == off);
  endfunction

  // one status bit: a set wins over a clear in the same cycle
  function automatic logic nextFlag(input logic cur,
                                    input logic setEv,
                                    input logic clrEv);
    nextFlag = setEv | (cur & ~clrEv);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [7:0]          settingQ;
  logic [7:0]          regInitQ;
  logic                mainStartQ;
  logic                extraStartQ;
  logic                mainDoneQ;
  logic                extraDoneQ;
  logic [5:0]          errorQ;
  logic [SHIELD_W-1:0] shieldStartQ;
  logic [SHIELD_W:0]   shieldEndQ;
  logic [31:0]         rdataQ;
  logic                slvErrQ;

  // ****************************************
  // bus decode
  // ****************************************
  logic setupPh;
  logic accessPh;
  logic wrEn;
  logic mapped;
  logic wrCtrl;
  logic [7:0] wByte;

  assign setupPh  = apbReq.psel & ~apbReq.penable;
  assign accessPh = apbReq.psel & apbReq.penable;
  assign wrEn     = accessPh & apbReq.pwrite;
  assign wByte    = apbReq.pwdata[7:0];
  assign wrCtrl   = wrEn & hitReg(apbReq.paddr, `FSS_OFF_ENGINE_CTRL);

  // every map entry is word aligned, anything else errors
  assign mapped = hitReg(apbReq.paddr, `FSS_OFF_STATUS_HIGH)
                | hitReg(apbReq.paddr, `FSS_OFF_ERROR_LOW)
                | hitReg(apbReq.paddr, `FSS_OFF_INIT_SETTING)
                | hitReg(apbReq.paddr, `FSS_OFF_REG_INIT)
                | hitReg(apbReq.paddr, `FSS_OFF_SHIELD_START)
                | hitReg(apbReq.paddr, `FSS_OFF_SHIELD_END)
                | hitReg(apbReq.paddr, `FSS_OFF_ENGINE_CTRL);

  // ****************************************
  // register initialisation control
  // ****************************************
  logic initAct;

  // level control: engine registers stay cleared while it reads 1
  // limitation: engine events in that time are lost, software writes 0 to release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regInitQ <= `FSS_RST_REG_INIT;
    end else if (wrEn && hitReg(apbReq.paddr, `FSS_OFF_REG_INIT)) begin
      regInitQ <= wByte & `FSS_INIT_MASK;
    end
  end

  assign initAct = regInitQ[`FSS_BIT_REG_INIT];

  // ****************************************
  // engine start bits
  // ****************************************
  // the start bits live here so that clearing them can end a run
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mainStartQ  <= 1'b0;
      extraStartQ <= 1'b0;
    end else if (initAct) begin
      mainStartQ  <= 1'b0;
      extraStartQ <= 1'b0;
    end else if (wrCtrl) begin
      mainStartQ  <= wByte[`FSS_BIT_MAIN_START];
      extraStartQ <= wByte[`FSS_BIT_EXTRA_START];
    end
  end

  // start edges clear the old errors of that engine
  logic mainLaunch;
  logic extraLaunch;
  logic mainStop;
  logic extraStop;

  assign mainLaunch  = wrCtrl & wByte[`FSS_BIT_MAIN_START] & ~mainStartQ;
  assign extraLaunch = wrCtrl & wByte[`FSS_BIT_EXTRA_START] & ~extraStartQ;
  assign mainStop    = wrCtrl & ~wByte[`FSS_BIT_MAIN_START];
  assign extraStop   = wrCtrl & ~wByte[`FSS_BIT_EXTRA_START];

  // ****************************************
  // completion flags
  // ****************************************
  // a done pulse in the cycle of a clearing control write is kept, not lost
  // done sets on the engine pulse alone, whatever the start bit holds
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mainDoneQ  <= 1'b0;
      extraDoneQ <= 1'b0;
    end else if (initAct) begin
      mainDoneQ  <= 1'b0;
      extraDoneQ <= 1'b0;
    end else begin
      mainDoneQ  <= nextFlag(mainDoneQ, engEvt.mainDone, mainStop);
      extraDoneQ <= nextFlag(extraDoneQ, engEvt.extraDone, extraStop);
    end
  end

  // ****************************************
  // error flags
  // ****************************************
  logic [5:0] errSet;
  logic [5:0] errClr;

  // bit order follows the low status byte
  always_comb begin
    errSet = '0;
    errSet[`FSS_BIT_EXTRA_ERR]  = engEvt.extraSeqErr;
    errSet[`FSS_BIT_MAIN_ERR]   = engEvt.mainSeqErr;
    errSet[`FSS_BIT_BLANK_ERR]  = engEvt.blankErr;
    errSet[`FSS_BIT_VERIFY_ERR] = engEvt.verifyErr;
    errSet[`FSS_BIT_PROG_ERR]   = engEvt.progErr;
    errSet[`FSS_BIT_ERASE_ERR]  = engEvt.eraseErr;
  end

  // extra engine owns its error bit, main engine the rest
  // so a launch of one engine never wipes the other engine's report
  always_comb begin
    errClr = {6{mainLaunch}};
    errClr[`FSS_BIT_EXTRA_ERR] = extraLaunch;
  end

  // flags are cleared only by an engine launch or register init, never by a write to the error register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      errorQ <= '0;
    end else if (initAct) begin
      errorQ <= '0;
    end else begin
      errorQ <= errSet | (errorQ & ~errClr);
    end
  end

  // ****************************************
  // initial setting register
  // ****************************************
  // bit 5 is reserved and reads zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      settingQ <= `FSS_RST_SETTING;
    end else if (wrEn && hitReg(apbReq.paddr, `FSS_OFF_INIT_SETTING)) begin
      settingQ <= wByte & `FSS_SETTING_MASK;
    end
  end

  // boot area: extra area choice unless the temporary mode is set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bootCluster1 <= 1'b0;
    end else if (settingQ[`FSS_BIT_SWAP_SRC]) begin
      bootCluster1 <= settingQ[`FSS_BIT_TEMP_CLUSTER];
    end else begin
      bootCluster1 <= extraAreaCluster1;
    end
  end

  // frequency code passed to the engines as written
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpuFrequencyCode <= '0;
    end else begin
      cpuFrequencyCode <= settingQ[`FSS_FREQ_MSB:0];
    end
  end

  // ****************************************
  // shield window monitors
  // ****************************************
  // end monitor is one past the last block, so a wide result is kept
  // a window ending at the top block reads 1024, one bit above the field
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shieldStartQ <= '0;
      shieldEndQ   <= '0;
    end else if (shieldUpdate) begin
      shieldStartQ <= shieldFirst;
      shieldEndQ   <= {1'b0, shieldLast} + {{SHIELD_W{1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  logic [31:0] rdMux;

  // unused bits above each register read zero
  always_comb begin
    rdMux = '0;
    if (hitReg(apbReq.paddr, `FSS_OFF_STATUS_HIGH)) begin
      rdMux[`FSS_BIT_EXTRA_DONE] = extraDoneQ;
      rdMux[`FSS_BIT_MAIN_DONE]  = mainDoneQ;
    end else if (hitReg(apbReq.paddr, `FSS_OFF_ERROR_LOW)) begin
      rdMux[5:0] = errorQ;
    end else if (hitReg(apbReq.paddr, `FSS_OFF_INIT_SETTING)) begin
      rdMux[7:0] = settingQ;
    end else if (hitReg(apbReq.paddr, `FSS_OFF_REG_INIT)) begin
      rdMux[7:0] = regInitQ;
    end else if (hitReg(apbReq.paddr, `FSS_OFF_SHIELD_START)) begin
      rdMux[SHIELD_W-1:0] = shieldStartQ;
    end else if (hitReg(apbReq.paddr, `FSS_OFF_SHIELD_END)) begin
      rdMux[SHIELD_W:0] = shieldEndQ;
    end else if (hitReg(apbReq.paddr, `FSS_OFF_ENGINE_CTRL)) begin
      rdMux[`FSS_BIT_MAIN_START]  = mainStartQ;
      rdMux[`FSS_BIT_EXTRA_START] = extraStartQ;
    end
  end

  // ****************************************
  // bus answer
  // ****************************************
  // data sampled in setup so prdata is a flop during the access phase;
  // a write in that access phase shows only on the next read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdataQ  <= '0;
      slvErrQ <= 1'b0;
    end else if (setupPh) begin
      rdataQ  <= apbReq.pwrite ? 32'h0000_0000 : rdMux;
      slvErrQ <= ~mapped;
    end
  end

  // zero wait states: every access ends in its first access cycle
  // writes land only at that access edge, never in the setup cycle
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = accessPh & slvErrQ;
  assign apbRsp.prdata  = rdataQ;

  // ****************************************
  // outputs to the engines
  // ****************************************
  // engines see the start bits straight from the flops, no added delay
  assign mainEngineStart  = mainStartQ;
  assign extraEngineStart = extraStartQ;
  assign seqRegInit       = initAct;

endmodule

// ===== rtl/fss_defines.svh
// constants for the flash sequencer status and setup block
// assumes a 32-bit APB with byte addresses, one register per aligned word
//
// Operation
// - main area engine completion shows in high status bit 6 (0x40)
// - extra area engine completion shows in high status bit 7 (0x80)
// - extra area engine sequencer error sets low status bit 5
// - main area engine sequencer error sets low status bit 4
// - blank check finding data sets low status bit 3
// - internal verify failure sets low status bit 2
// - failed write command sets low status bit 1
// - failed block erase sets low status bit 0
// - setting bit 7 clear: boot swap from extra area, else cluster select
// - setting bit 6 picks temporary boot cluster 0 or 1
// - init control 0x01 resets engine registers, 0x00 leaves them
// - window end monitor bits 10..0 hold last protected block plus one
// - window start monitor bits 9..0 hold first protected block
// - extra area completion clears when its start bit clears
// - main area completion clears when its start bit clears
`ifndef FSS_DEFINES_SVH
`define FSS_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define FSS_OFF_STATUS_HIGH   8'h00
`define FSS_OFF_ERROR_LOW     8'h04
`define FSS_OFF_INIT_SETTING  8'h08
`define FSS_OFF_REG_INIT      8'h0C
`define FSS_OFF_SHIELD_START  8'h10
`define FSS_OFF_SHIELD_END    8'h14
`define FSS_OFF_ENGINE_CTRL   8'h18

// ****************************************
// field positions
// ****************************************
`define FSS_BIT_EXTRA_DONE    7
`define FSS_BIT_MAIN_DONE     6
`define FSS_BIT_EXTRA_ERR     5
`define FSS_BIT_MAIN_ERR      4
`define FSS_BIT_BLANK_ERR     3
`define FSS_BIT_VERIFY_ERR    2
`define FSS_BIT_PROG_ERR      1
`define FSS_BIT_ERASE_ERR     0
`define FSS_BIT_SWAP_SRC      7
`define FSS_BIT_TEMP_CLUSTER  6
`define FSS_FREQ_MSB          4
`define FSS_BIT_REG_INIT      0
`define FSS_BIT_MAIN_START    7
`define FSS_BIT_EXTRA_START   6
`define FSS_ERROR_MASK        8'h3F
`define FSS_SETTING_MASK      8'hDF
`define FSS_INIT_MASK         8'h01

// ****************************************
// reset values and limits
// ****************************************
`define FSS_RST_SETTING       8'h00
`define FSS_RST_REG_INIT      8'h00
`define FSS_RST_STATUS        8'h00
`define FSS_FREQ_MIN_MHZ      2
`define FSS_FREQ_MAX_MHZ      40

`endif

// ===== rtl/fss_pkg.sv
// types shared by the flash sequencer status and setup block
// assumes the constants header is included alongside
package fss_pkg;

  // ****************************************
  // bus carriers
  // ****************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } fss_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } fss_apb_rsp_t;

  // ****************************************
  // engine event pulses, one cycle each
  // ****************************************
  typedef struct packed {
    logic mainDone;
    logic extraDone;
    logic extraSeqErr;
    logic mainSeqErr;
    logic blankErr;
    logic verifyErr;
    logic progErr;
    logic eraseErr;
  } fss_evt_t;

endpackage

// ===== tb/fss_status_setup_props.sv
// concurrent checks for the flash sequencer status and setup block
// assumes it is bound into fss_status_setup and sees only its ports
`timescale 1ns/10ps

module fss_status_setup_props
  import fss_pkg::*;
#(
  parameter int SHIELD_W = 10
) (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire fss_pkg::fss_apb_req_t apbReq,
  input wire fss_pkg::fss_apb_rsp_t apbRsp,
  input wire fss_pkg::fss_evt_t     engEvt,
  input wire logic [SHIELD_W-1:0]   shieldFirst,
  input wire logic [SHIELD_W-1:0]   shieldLast,
  input wire logic                  shieldUpdate,
  input wire logic                  extraAreaCluster1,
  input wire logic                  mainEngineStart,
  input wire logic                  extraEngineStart,
  input wire logic                  seqRegInit,
  input wire logic                  bootCluster1,
  input wire logic [4:0]            cpuFrequencyCode
);
  // ****************************************
  // bus phase decode
  // ****************************************
  logic       wrAcc;
  logic       rdSet;
  logic       wrSet;
  logic       wrCtl;
  logic [7:0] adr;

  // read data is captured at the setup edge, so reads are keyed there
  assign adr   = apbReq.paddr;
  assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign rdSet = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
  assign wrSet = wrAcc && adr == 8'h08;
  assign wrCtl = wrAcc && adr == 8'h18;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_freq_load: assert property (
    wrSet |=> ##1 cpuFrequencyCode == $past(apbReq.pwdata[4:0], 2))
    else $error("frequency code not loaded");
  a_boot_temp: assert property (
    wrSet && apbReq.pwdata[7] ##1 !wrSet |=> bootCluster1 == $past(apbReq.pwdata[6], 2))
    else $error("temporary cluster not followed");
  a_boot_area: assert property (
    wrSet && !apbReq.pwdata[7] ##1 !wrSet |=> bootCluster1 == $past(extraAreaCluster1))
    else $error("extra area boot choice not followed");
  a_init_hold: assert property (
    seqRegInit |=> !mainEngineStart && !extraEngineStart)
    else $error("start bits not held by register init");
  a_main_done: assert property (
    engEvt.mainDone && !seqRegInit ##1 !wrCtl ##1 rdSet && adr == 8'h00 |=> apbRsp.prdata[6])
    else $error("main done not reported");
  a_extra_done: assert property (
    engEvt.extraDone && !seqRegInit ##1 !wrCtl ##1 rdSet && adr == 8'h00 |=> apbRsp.prdata[7])
    else $error("extra done not reported");
  a_main_clear: assert property (
    wrCtl && !apbReq.pwdata[7] && !engEvt.mainDone ##1 !engEvt.mainDone ##1 rdSet
    && adr == 8'h00 |=> !apbRsp.prdata[6])
    else $error("main done not cleared");
  a_extra_clear: assert property (
    wrCtl && !apbReq.pwdata[6] && !engEvt.extraDone ##1 !engEvt.extraDone ##1 rdSet
    && adr == 8'h00 |=> !apbRsp.prdata[7])
    else $error("extra done not cleared");
  a_err_flags: assert property (
    engEvt[5:0] != 6'h00 && !seqRegInit ##2 rdSet && adr == 8'h04
    |=> (apbRsp.prdata[5:0] & $past(engEvt[5:0], 3)) == $past(engEvt[5:0], 3))
    else $error("error flag not reported");
  a_win_start: assert property (
    shieldUpdate ##1 !shieldUpdate ##1 rdSet && adr == 8'h10
    |=> apbRsp.prdata[SHIELD_W-1:0] == $past(shieldFirst, 3))
    else $error("window start wrong");
  a_win_end: assert property (
    shieldUpdate ##1 !shieldUpdate ##1 rdSet && adr == 8'h14
    |=> apbRsp.prdata[SHIELD_W:0] == {1'b0, $past(shieldLast, 3)} + 1'b1)
    else $error("window end wrong");
  a_bad_addr: assert property (
    apbReq.psel && apbReq.penable |-> apbRsp.pslverr == (adr > 8'h18 || adr[1:0] != 2'b00))
    else $error("slave error does not match the map");

  // main scenarios reached
  c_temp_swap: cover property (wrSet && apbReq.pwdata[7]);
  c_init_drop: cover property (seqRegInit && engEvt.mainDone);
  c_slv_err: cover property (apbRsp.pslverr);
endmodule

bind fss_status_setup fss_status_setup_props #(.SHIELD_W(SHIELD_W)) u_props (
  .mclk(mclk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .engEvt(engEvt),
  .shieldFirst(shieldFirst), .shieldLast(shieldLast), .shieldUpdate(shieldUpdate),
  .extraAreaCluster1(extraAreaCluster1), .mainEngineStart(mainEngineStart),
  .extraEngineStart(extraEngineStart), .seqRegInit(seqRegInit),
  .bootCluster1(bootCluster1), .cpuFrequencyCode(cpuFrequencyCode));

// ===== tb/test_fss_status_setup.sv
// self-checking bench for the flash sequencer status and setup block
// assumes the package and design compile ahead of it
`timescale 1ns/10ps

module test_fss_status_setup;
  import fss_pkg::*;

  logic         mclk;
  logic         rst_n;
  fss_apb_req_t apbReq;
  fss_apb_rsp_t apbRsp;
  fss_evt_t     engEvt;
  logic [9:0]   shieldFirst;
  logic [9:0]   shieldLast;
  logic         shieldUpdate;
  logic         extraAreaCluster1;
  logic         mainEngineStart;
  logic         extraEngineStart;
  logic         seqRegInit;
  logic         bootCluster1;
  logic [4:0]   cpuFrequencyCode;
  logic [31:0]  rdData;
  logic         rdErr;
  int           bad_count;
  int           cmp_count;

  fss_status_setup #(.SHIELD_W(10)) dut (
    .mclk(mclk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .engEvt(engEvt),
    .shieldFirst(shieldFirst), .shieldLast(shieldLast), .shieldUpdate(shieldUpdate),
    .extraAreaCluster1(extraAreaCluster1), .mainEngineStart(mainEngineStart),
    .extraEngineStart(extraEngineStart), .seqRegInit(seqRegInit),
    .bootCluster1(bootCluster1), .cpuFrequencyCode(cpuFrequencyCode));

  // ****************************************
  // clock, bus and compare tasks
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; an idle edge follows so psel never toggles twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    // wait states are polled on pready: only the hang guard ends a missing answer
    do begin
      @(posedge mclk);
    end while (apbRsp.pready !== 1'b1);
    rdData = apbRsp.prdata;
    rdErr = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rdData, exp);
  endtask

  task automatic pulse(input logic [7:0] m);
    engEvt <= m;
    @(posedge mclk);
    engEvt <= 8'h00;
    @(posedge mclk);
  endtask

  task automatic stop_test;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    apbReq = '0;
    engEvt = '0;
    shieldFirst = 10'h000;
    shieldLast = 10'h000;
    shieldUpdate = 1'b0;
    extraAreaCluster1 = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i), 32'h0000_0000);
    end
    apb(1'b1, 8'h08, 32'h0000_00FF);
    rd(8'h08, 32'h0000_00DF);
    cmp(32'(cpuFrequencyCode), 32'h0000_001F);
    cmp(32'(bootCluster1), 32'h0000_0001);
    apb(1'b1, 8'h08, 32'h0000_009F);
    rd(8'h08, 32'h0000_009F);
    cmp(32'(bootCluster1), 32'h0000_0000);
    extraAreaCluster1 <= 1'b1;
    apb(1'b1, 8'h08, 32'h0000_001F);
    rd(8'h08, 32'h0000_001F);
    cmp(32'(bootCluster1), 32'h0000_0001);
    // error flags gather one at a time and stay until cleared
    for (int i = 0; i < 6; i++) begin
      pulse(8'(1 << i));
      rd(8'h04, 32'((1 << (i + 1)) - 1));
    end
    pulse(8'hC0);
    rd(8'h00, 32'h0000_00C0);
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_0000);
    rd(8'h00, 32'h0000_00C0);
    rd(8'h04, 32'h0000_003F);
    apb(1'b1, 8'h18, 32'h0000_0040);
    rd(8'h00, 32'h0000_0080);
    rd(8'h04, 32'h0000_001F);
    cmp(32'(extraEngineStart), 32'h0000_0001);
    apb(1'b1, 8'h18, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    pulse(8'h20);
    apb(1'b1, 8'h18, 32'h0000_0080);
    rd(8'h04, 32'h0000_0020);
    // register init holds the engine side at zero, setting survives
    apb(1'b1, 8'h0C, 32'h0000_0001);
    rd(8'h0C, 32'h0000_0001);
    cmp(32'(seqRegInit), 32'h0000_0001);
    pulse(8'hC0);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    cmp(32'(mainEngineStart), 32'h0000_0000);
    rd(8'h08, 32'h0000_001F);
    apb(1'b1, 8'h0C, 32'h0000_0000);
    cmp(32'(seqRegInit), 32'h0000_0000);
    pulse(8'h80);
    rd(8'h00, 32'h0000_0040);
    shieldFirst <= 10'h005;
    shieldLast <= 10'h3FF;
    shieldUpdate <= 1'b1;
    @(posedge mclk);
    shieldUpdate <= 1'b0;
    @(posedge mclk);
    rd(8'h10, 32'h0000_0005);
    rd(8'h14, 32'h0000_0400);
    rd(8'h1C, 32'h0000_0000);
    cmp(32'(rdErr), 32'h0000_0001);
    // a second reset mid-run returns setting and monitors to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(8'h08, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    cmp(32'(bootCluster1), 32'h0000_0001);
    stop_test;
  end

  // hang guard, far beyond the fewer than two hundred cycles the sequence needs
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    stop_test;
  end
endmodule
